// >>> hw/hsw_pkg.sv
// Constants shared by the slave halt/step wait generator
package hsw_pkg;
	// ***************************************************************
	// Slave bus geometry
	// ***************************************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// ***************************************************************
	// Reserved transceiver / halt window
	// ***************************************************************
	localparam logic [15:0] WIN_BASE = 16'h2000;
	localparam logic [15:0] WIN_LAST = 16'h2fff;

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic HOLD_RELEASED = 1'b1;
	localparam logic STROBE_IDLE   = 1'b1;
	localparam logic STEP_IDLE     = 1'b0;
	localparam logic [7:0] LATCH_RST = 8'h00;

	typedef enum logic [0:0] {
		HSW_RUN,
		HSW_HELD
	} hsw_state_t;
endpackage : hsw_pkg

// >>> hw/hsw_wait_gen.sv
// Halt/step wait generator with transceiver decode for a slave processor
//
// How it works
// - Slave wait is hold request AND proto wait
// - Stop when halt low or address 2xxxh
// - Hold asserted at strobe falling edge under stop
// - Hold stays latched until master releases
// - Step rising edge releases the hold
// - Each release advances exactly one strobe cycle
// - Only transceiver decoded in 2xxxh window
// - Window decode permanently enabled, no disable
// - Master bytes latched and driven on slave read
// - Master reads live slave bus, slave writes ignored
`timescale 1ns/100ps
`default_nettype none
module hsw_wait_gen #(
	parameter int ADDR_W = hsw_pkg::ADDR_W,
	parameter int DATA_W = hsw_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	// Slave bus
	input  wire logic [ADDR_W-1:0] slave_addr_i,
	input  wire logic              external_data_strobe_n_i,
	input  wire logic              slave_rd_i,
	input  wire logic              opcode_fetch_strobe_n_i,
	input  wire logic [DATA_W-1:0] slave_data_i,
	output logic      [DATA_W-1:0] slave_data_o,
	output logic                   slave_data_oe_o,
	output logic                   slave_wait_n_o,
	output logic                   ext_mem_disable_o,
	// Prototype area
	input  wire logic              proto_hold_in_n_i,
	// Master I/O
	input  wire logic              master_halt_request_n_i,
	input  wire logic              step_release_i,
	input  wire logic              bus_override_n_i,
	input  wire logic              master_xcvr_wr_i,
	input  wire logic [DATA_W-1:0] master_wr_data_i,
	output logic      [DATA_W-1:0] master_rd_data_o,
	output logic                   opcode_fetch_strobe_n_o,
	output logic                   external_data_strobe_n_o,
	output logic                   hold_request_n_o
);
	// ***************************************************************
	// Elaboration checks
	// ***************************************************************
	if (ADDR_W != 16) begin : g_bad_addr
		$error("hsw_wait_gen: address width must be 16");
	end
	if (DATA_W < 1) begin : g_bad_data
		$error("hsw_wait_gen: data width must be positive");
	end

	// ***************************************************************
	// Window decode
	// ***************************************************************
	function automatic logic in_window(input logic [ADDR_W-1:0] a);
		in_window = (a >= hsw_pkg::WIN_BASE) && (a <= hsw_pkg::WIN_LAST);
	endfunction : in_window

	logic win_hit;
	logic stop;
	// No enable term: the window decode cannot be switched off
	assign win_hit = in_window(slave_addr_i);
	assign stop    = !master_halt_request_n_i || win_hit;

	// ***************************************************************
	// Edge detection and hold state
	// ***************************************************************
	hsw_pkg::hsw_state_t state;
	hsw_pkg::hsw_state_t next_state;
	logic strobe_q;
	logic next_strobe_q;
	logic step_q;
	logic next_step_q;
	logic strobe_fall;
	logic step_rise;

	assign strobe_fall = strobe_q && !external_data_strobe_n_i;
	assign step_rise   = !step_q && step_release_i;

	always_comb begin
		next_strobe_q = external_data_strobe_n_i;
		next_step_q   = step_release_i;
		next_state    = state;
		case (state)
			hsw_pkg::HSW_RUN: begin
				// Arm only on a fresh strobe fall, so a release passes one cycle
				if (strobe_fall && stop) begin
					next_state = hsw_pkg::HSW_HELD;
				end
			end
			hsw_pkg::HSW_HELD: begin
				// Level of the step line is ignored; only its rising edge counts
				if (step_rise) begin
					next_state = hsw_pkg::HSW_RUN;
				end
			end
			default: next_state = hsw_pkg::HSW_RUN;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state    <= hsw_pkg::HSW_RUN;
			strobe_q <= hsw_pkg::STROBE_IDLE;
			step_q   <= hsw_pkg::STEP_IDLE;
		end else begin
			state    <= next_state;
			strobe_q <= next_strobe_q;
			step_q   <= next_step_q;
		end
	end

	// Strobe-fall is seen one clock late; the slave samples wait late in its cycle
	assign hold_request_n_o = (state == hsw_pkg::HSW_RUN);
	assign slave_wait_n_o   = hold_request_n_o && proto_hold_in_n_i;

	// ***************************************************************
	// Transceiver
	// ***************************************************************
	logic [DATA_W-1:0] latched;

	hsw_xcvr_latch #(
		.DATA_W (DATA_W)
	) u_latch (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.wr_en_i   (master_xcvr_wr_i),
		.wr_data_i (master_wr_data_i),
		.rd_data_o (latched)
	);

	logic override;
	assign override          = !bus_override_n_i;
	assign ext_mem_disable_o = override || win_hit;
	assign slave_data_o      = latched;
	// Slave writes never turn the driver on
	assign slave_data_oe_o   = !external_data_strobe_n_i && slave_rd_i
		&& (win_hit || override);

	logic [DATA_W-1:0] mrd;
	logic [DATA_W-1:0] next_mrd;
	always_comb begin
		next_mrd = slave_data_i;
	end
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mrd <= '0;
		end else begin
			mrd <= next_mrd;
		end
	end
	assign master_rd_data_o = mrd;

	// Slave strobes pass straight to the master
	assign opcode_fetch_strobe_n_o  = opcode_fetch_strobe_n_i;
	assign external_data_strobe_n_o = external_data_strobe_n_i;

	// ***************************************************************
	// Assertions
	// ***************************************************************
	sequence s_armed;
		strobe_fall && stop && state == hsw_pkg::HSW_RUN;
	endsequence
	sequence s_released;
		state == hsw_pkg::HSW_HELD && step_rise;
	endsequence

	a_stop_holds: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		s_armed |=> !hold_request_n_o) else $error("hold not raised on stop strobe");
	a_step_frees: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		s_released |=> hold_request_n_o) else $error("step did not release hold");
	a_hold_latched: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(!hold_request_n_o && !step_rise) |=> !hold_request_n_o)
		else $error("hold dropped without step");
	a_wait_and: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		slave_wait_n_o == (hold_request_n_o && proto_hold_in_n_i))
		else $error("wait is not AND of hold and proto");
	a_window_stop: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(slave_addr_i == hsw_pkg::WIN_BASE && strobe_fall && hold_request_n_o)
		|=> !hold_request_n_o) else $error("window access did not halt");
	a_no_spurious: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(hold_request_n_o && !(strobe_fall && stop)) |=> hold_request_n_o)
		else $error("hold raised without stop strobe");
	a_latch_drive: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		master_xcvr_wr_i |=> slave_data_o == $past(master_wr_data_i))
		else $error("latched byte not driven");
	// Halt request alone must stop the slave anywhere outside the window
	a_halt_stop: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(!master_halt_request_n_i && strobe_fall && hold_request_n_o)
		|=> !hold_request_n_o) else $error("halt request did not halt");
	// Both the window and the override put the latched byte on a slave read
	a_window_drive: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(win_hit && !external_data_strobe_n_i && slave_rd_i)
		|-> slave_data_oe_o) else $error("window read not driven");
	a_override_drive: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(!bus_override_n_i && !external_data_strobe_n_i && slave_rd_i)
		|-> slave_data_oe_o) else $error("override read not driven");
	a_slave_wr_ignored: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!slave_rd_i |-> !slave_data_oe_o) else $error("driver on in slave write");
	a_master_live: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		1'b1 |=> master_rd_data_o == $past(slave_data_i))
		else $error("master read not live bus");
	a_mem_off_window: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		win_hit |-> ext_mem_disable_o) else $error("memory enabled in window");
endmodule : hsw_wait_gen
`default_nettype wire

// >>> hw/hsw_xcvr_latch.sv
// Byte latch of the master-to-slave transceiver
`timescale 1ns/100ps
`default_nettype none
module hsw_xcvr_latch #(
	parameter int DATA_W = 8
) (
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	// Write side
	input  wire logic              wr_en_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	// Read side
	output logic      [DATA_W-1:0] rd_data_o
);
	logic [DATA_W-1:0] store;
	logic [DATA_W-1:0] next_store;

	always_comb begin
		next_store = wr_en_i ? wr_data_i : store;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			store <= '0;
		end else begin
			store <= next_store;
		end
	end

	assign rd_data_o = store;
endmodule : hsw_xcvr_latch
`default_nettype wire

// >>> testbench/hsw_slave_model.sv
// Behavioural slave processor external bus for the wait generator bench
`timescale 1ns/100ps
`default_nettype none
module hsw_slave_model (
	// Clock
	input  wire logic        clk_i,
	// Slave bus
	input  wire logic        wait_n_i,
	output logic      [15:0] addr_o,
	output logic      [7:0]  data_o,
	output logic             strobe_n_o,
	output logic             rd_o,
	output logic             fetch_n_o
);
	initial begin
		addr_o = 16'h0000;
		data_o = 8'h00;
		strobe_n_o = 1'b1;
		rd_o = 1'b1;
		fetch_n_o = 1'b1;
	end

	// One off-chip cycle; reads are taken as opcode fetches
	task automatic cycle(input logic [15:0] a, input logic r);
		int n;
		@(negedge clk_i);
		addr_o = a;
		data_o = a[7:0];
		rd_o = r;
		fetch_n_o = !r;
		strobe_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
		n = 0;
		// Bus stays frozen while waited; bounded so a stuck hold cannot hang us
		while (wait_n_i !== 1'b1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		strobe_n_o = 1'b1;
		fetch_n_o = 1'b1;
		// Released bus shows the inverse so stale values never look valid
		addr_o = ~a;
		data_o = ~a[7:0];
	endtask : cycle
endmodule : hsw_slave_model
`default_nettype wire

// >>> testbench/slave_halt_step_wait_generator_tb.sv
// Self-checking bench for the halt/step wait generator
`timescale 1ns/100ps
`default_nettype none
module slave_halt_step_wait_generator_tb;
	logic clk = 1'b0, rst_n = 1'b0, proto_n = 1'b1, halt_n = 1'b1, step = 1'b0;
	logic ovr_n = 1'b1, mwr = 1'b0, oe, wait_n, dis, fetch_o, hold_n, stb, rd, fetch, stb_o;
	logic [7:0] mwd = 8'h00, xbyte = 8'h00, sdi, sdo, mrd;
	logic [15:0] addr;
	int err_count = 0, compares = 0, cycles = 0;

	always #2.5 clk = ~clk;

	hsw_slave_model hsw_slave_model_i (.clk_i(clk), .wait_n_i(wait_n), .addr_o(addr),
		.data_o(sdi), .strobe_n_o(stb), .rd_o(rd), .fetch_n_o(fetch));

	hsw_wait_gen hsw_wait_gen_i (.clk_sys_i(clk), .arst_n_i(rst_n), .slave_addr_i(addr),
		.external_data_strobe_n_i(stb), .slave_rd_i(rd), .opcode_fetch_strobe_n_i(fetch),
		.slave_data_i(sdi), .slave_data_o(sdo), .slave_data_oe_o(oe), .slave_wait_n_o(wait_n),
		.ext_mem_disable_o(dis), .proto_hold_in_n_i(proto_n), .master_halt_request_n_i(halt_n),
		.step_release_i(step), .bus_override_n_i(ovr_n), .master_xcvr_wr_i(mwr),
		.master_wr_data_i(mwd), .master_rd_data_o(mrd), .opcode_fetch_strobe_n_o(fetch_o),
		.external_data_strobe_n_o(stb_o), .hold_request_n_o(hold_n));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// ***************************************************************
	// One slave cycle with expectations derived from the stop decode
	// ***************************************************************
	task automatic run_cycle(input logic [15:0] a, input logic r, input logic h, input logic o);
		logic win;
		logic held;
		win = (a >= hsw_pkg::WIN_BASE) && (a <= hsw_pkg::WIN_LAST);
		held = win || !h;
		halt_n = h;
		ovr_n = o;
		fork
			hsw_slave_model_i.cycle(a, r);
			begin
				repeat (3) @(negedge clk);
				check(hold_n, !held);
				check(wait_n, !held);
				check(oe, r && (win || !o));
				check(dis, win || !o);
				check(mrd, a[7:0]);
				check(fetch_o, !r);
				check(stb_o, 1'b0);
				check(sdo, xbyte);
				repeat (3) @(negedge clk);
				check(hold_n, !held);
				step = 1'b1;
				@(negedge clk);
				step = 1'b0;
				@(negedge clk);
				check(hold_n, 1'b1);
			end
		join
		halt_n = 1'b1;
		ovr_n = 1'b1;
		// Let an edge pass so the next call never re-drives these in the same step
		@(negedge clk);
	endtask : run_cycle

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_window();
		logic [15:0] tbl [4] = '{16'h1fff, 16'h2000, 16'h2fff, 16'h3000};
		// Back-to-back window cycles must each be held again
		for (int i = 0; i < 4; i++)
			run_cycle(tbl[i], i[0], 1'b1, 1'b1);
	endtask : t_window

	task automatic t_halt();
		// User addresses stay clear of the monitor area and its trap
		run_cycle(16'h4000, 1'b1, 1'b0, 1'b1);
		run_cycle(16'h4001, 1'b1, 1'b1, 1'b0);
	endtask : t_halt

	task automatic t_proto();
		proto_n = 1'b0;
		@(negedge clk);
		check(wait_n, 1'b0);
		check(hold_n, 1'b1);
		proto_n = 1'b1;
		@(negedge clk);
		check(wait_n, 1'b1);
	endtask : t_proto

	task automatic t_xcvr();
		mwr = 1'b1;
		mwd = 8'h5a;
		@(negedge clk);
		mwd = 8'hc3;
		xbyte = 8'hc3;
		@(negedge clk);
		mwr = 1'b0;
		@(negedge clk);
		check(sdo, 8'hc3);
	endtask : t_xcvr

	always @(posedge clk) begin
		cycles++;
		// Whole run needs well under a thousand cycles
		if (cycles == 5000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		repeat (12) @(negedge clk);
		check(hold_n, 1'b1);
		check(sdo, hsw_pkg::LATCH_RST);
		rst_n = 1'b1;
		@(negedge clk);
		t_proto();
		t_xcvr();
		t_window();
		t_halt();
		summarize();
	end
endmodule : slave_halt_step_wait_generator_tb
`default_nettype wire
